// ===== verilog/sleep_power_reset_defs.vh
`ifndef SLEEP_POWER_RESET_DEFS_VH
`define SLEEP_POWER_RESET_DEFS_VH
// ----------------------------------------
// register byte addresses (printed offsets are indices, address is 4x)
// ----------------------------------------
`define IDX_PERIPHERAL_CLOCK_GATE 8'h35
`define IDX_SLEEP_CONTROL         8'h3a
`define IDX_SUPPLY_MONITOR        8'h3b
`define IDX_RESET_STATUS          8'h3c
`define ADDR_PERIPHERAL_CLOCK_GATE 12'h0d4
`define ADDR_SLEEP_CONTROL         12'h0e8
`define ADDR_SUPPLY_MONITOR        12'h0ec
`define ADDR_RESET_STATUS          12'h0f0
// ----------------------------------------
// field positions
// ----------------------------------------
`define SE_BIT        0
`define SM_LSB        1
`define SM_MSB        3
`define PR_TIMER_BIT  0
`define PR_CONV_BIT   1
`define PR_SERIAL_BIT 2
`define VLM_LVL_LSB   0
`define VLM_LVL_MSB   2
`define VLM_IE_BIT    3
`define VLM_RST_BIT   4
`define VLM_FLAG_BIT  7
`define RS_POR_BIT    0
`define RS_EXT_BIT    1
`define RS_WDT_BIT    2
`define RS_VLM_BIT    3
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define SLEEP_CONTROL_RESET 8'h00
`define CLOCK_GATE_RESET    8'h00
`define MONITOR_RESET       8'h00
`define SM_IDLE      3'h0
`define SM_NOISE_RED 3'h1
`define SM_POWERDOWN 3'h2
`define SM_STANDBY   3'h4
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS    50
`define EXT_MIN_PULSE_NS 2500
`define WAKE_HALT_CYCLES 4
`endif

// ===== verilog/sleep_power_reset_control.v
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "sleep_power_reset_defs.vh"
module sleep_power_reset_control
#(
  parameter TIMEOUT_CYCLES = 1310720,
  parameter STARTUP_CYCLES = 16
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        por_active_n,
  input  wire        supply_below_level,
  input  wire        external_reset_n,
  input  wire        external_reset_disable_fuse,
  input  wire        watchdog_timeout,
  input  wire        watchdog_reset_mode,
  input  wire        sleep_instruction,
  input  wire        wake_interrupt,
  output wire        port_reset_n,
  output wire        core_reset_n,
  output wire        reset_vector_fetch,
  output wire        cpu_halt,
  output reg  [2:0]  sleep_mode_active,
  output reg         sleeping,
  output wire        serial_clock_en,
  output wire        converter_enable,
  output wire        comparator_mux_allow,
  output wire        timer_clock_en,
  output wire        supply_low_irq
);
  // ----------------------------------------
  // derived timing
  // ----------------------------------------
  localparam [31:0] EXT_MIN_CYCLES = (`EXT_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [6:0]  EXT_MIN_C      = EXT_MIN_CYCLES[6:0];
  localparam [31:0] TOUT_C = TIMEOUT_CYCLES;
  localparam [31:0] HALT_C = STARTUP_CYCLES + `WAKE_HALT_CYCLES;
  // states of the sleep controller
  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_SLEEP = 2'b01;
  localparam [1:0] ST_WAKE  = 2'b10;

  reg  [7:0]  sleep_control_q;
  reg  [7:0]  peripheral_clock_gate_q;
  reg  [7:0]  supply_monitor_ctrl_status_q;
  reg  [3:0]  reset_cause_q;
  reg         por_s1_q, por_s2_q;
  reg         ext_s1_q, ext_s2_q;
  reg         sup_s1_q, sup_s2_q;
  reg         wdt_s1_q, wdt_s2_q, wdt_s3_q;
  reg         wdt_mode_s1_q, wdt_mode_s2_q;
  reg  [6:0]  ext_low_cnt_q;
  reg         ext_hold_q;
  reg         wdt_pulse_q;
  reg  [31:0] delay_cnt_q;
  reg         stretch_q;
  reg         stretch_d1_q;
  reg  [1:0]  state_q;
  reg  [31:0] halt_cnt_q;
  reg         por_seen_q;
  wire        wr;
  wire        rd;
  wire        any_source;
  wire        vlm_reset;
  wire        ext_reset;
  wire        async_rst_n;
  wire        supply_low_s;
  wire [3:0]  cause_set;

  // ----------------------------------------
  // reset source combination
  // ----------------------------------------
  // asynchronous path: power-on and the raw pin act without a clock
  assign async_rst_n = presetn & por_active_n &
                       (external_reset_n | external_reset_disable_fuse);
  assign supply_low_s = sup_s2_q;
  assign vlm_reset    = supply_low_s & supply_monitor_ctrl_status_q[`VLM_RST_BIT];
  assign ext_reset    = ext_hold_q & ~external_reset_disable_fuse;
  assign any_source   = ~por_s2_q | vlm_reset | ext_reset | wdt_pulse_q;
  assign port_reset_n = async_rst_n & ~any_source;
  assign core_reset_n = port_reset_n & ~stretch_q;
  // one-cycle fetch strobe, only when the core really leaves reset
  assign reset_vector_fetch = stretch_d1_q & core_reset_n;
  // reset causes seen this cycle; a restored supply marks power-on
  assign cause_set[`RS_POR_BIT] = por_s2_q & por_seen_q;
  assign cause_set[`RS_EXT_BIT] = ext_reset;
  assign cause_set[`RS_WDT_BIT] = wdt_pulse_q;
  assign cause_set[`RS_VLM_BIT] = vlm_reset;

  // input synchronisers; first stage read only by second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      wdt_s1_q <= 1'b0;
      wdt_s2_q <= 1'b0;
      wdt_s3_q <= 1'b0;
      wdt_mode_s1_q <= 1'b0;
      wdt_mode_s2_q <= 1'b0;
    end
    else
    begin
      por_s1_q <= por_active_n;
      por_s2_q <= por_s1_q;
      ext_s1_q <= external_reset_n;
      ext_s2_q <= ext_s1_q;
      sup_s1_q <= supply_below_level;
      sup_s2_q <= sup_s1_q;
      wdt_s1_q      <= watchdog_timeout;
      wdt_s2_q      <= wdt_s1_q;
      wdt_mode_s1_q <= watchdog_reset_mode;
      wdt_mode_s2_q <= wdt_mode_s1_q;
      wdt_s3_q      <= wdt_s2_q & wdt_mode_s2_q;
    end
  end

  // external filter and watchdog one-cycle pulse
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_low_cnt_q <= 7'h00;
      ext_hold_q    <= 1'b0;
      wdt_pulse_q   <= 1'b0;
    end
    else
    begin
      wdt_pulse_q <= wdt_s2_q & wdt_mode_s2_q & ~wdt_s3_q;
      if (ext_s2_q)
      begin
        ext_low_cnt_q <= 7'h00;
        ext_hold_q    <= 1'b0;
      end
      else if (ext_low_cnt_q < EXT_MIN_C)
        ext_low_cnt_q <= ext_low_cnt_q + 7'h01;
      else
        ext_hold_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // delay counter
  // ----------------------------------------
  // restarts while any source holds; runs only after all go inactive
  always @(posedge pclk or negedge async_rst_n)
  begin
    if (!async_rst_n)
    begin
      delay_cnt_q  <= 32'h0;
      stretch_q    <= 1'b1;
      stretch_d1_q <= 1'b1;
    end
    else
    begin
      stretch_d1_q <= stretch_q;
      if (any_source)
      begin
        delay_cnt_q <= 32'h0;
        stretch_q   <= 1'b1;
      end
      else if (stretch_q)
      begin
        if (delay_cnt_q >= TOUT_C - 32'h1)
          stretch_q <= 1'b0;
        else
          delay_cnt_q <= delay_cnt_q + 32'h1;
      end
    end
  end

  // power-on flag survives the stretch; set once supply is back
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      por_seen_q    <= 1'b0;
      reset_cause_q <= 4'h0;
    end
    else
    begin
      if (!por_s2_q)
        por_seen_q <= 1'b1;
      else if (por_seen_q)
        por_seen_q <= 1'b0;
      // a new cause and a clearing write in one cycle: the cause wins
      if (wr && paddr == `ADDR_RESET_STATUS)
        reset_cause_q <= (reset_cause_q & ~pwdata[3:0]) | cause_set;
      else
        reset_cause_q <= reset_cause_q | cause_set;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pslverr = psel & penable &
                   (paddr != `ADDR_SLEEP_CONTROL) & (paddr != `ADDR_PERIPHERAL_CLOCK_GATE) &
                   (paddr != `ADDR_SUPPLY_MONITOR) & (paddr != `ADDR_RESET_STATUS);

  // registers return to initial values while the core is held
  always @(posedge pclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
    begin
      sleep_control_q              <= `SLEEP_CONTROL_RESET;
      peripheral_clock_gate_q      <= `CLOCK_GATE_RESET;
    end
    else
    begin
      if (wr && paddr == `ADDR_SLEEP_CONTROL)
        sleep_control_q <= {4'h0, pwdata[3:0]};
      if (wr && paddr == `ADDR_PERIPHERAL_CLOCK_GATE)
        peripheral_clock_gate_q <= {5'h00, pwdata[2:0]};
    end
  end

  // monitor setup is cleared by presetn, power-on and the pin only: were it
  // cleared by the reset it raises, that reset would drop its own cause
  always @(posedge pclk or negedge async_rst_n)
  begin
    if (!async_rst_n)
      supply_monitor_ctrl_status_q <= `MONITOR_RESET;
    else
    begin
      // flag: set while the supply is low, cleared as soon as the level recovers; a write cannot clear it while low
      if (supply_low_s)
        supply_monitor_ctrl_status_q[`VLM_FLAG_BIT] <= 1'b1;
      else
        supply_monitor_ctrl_status_q[`VLM_FLAG_BIT] <= 1'b0;
      if (wr && core_reset_n && paddr == `ADDR_SUPPLY_MONITOR)
      begin
        supply_monitor_ctrl_status_q[6:0] <= {2'h0, pwdata[4:0]};
        if (!supply_low_s && (!pwdata[`VLM_FLAG_BIT] ||
            pwdata[2:0] != supply_monitor_ctrl_status_q[2:0]))
          supply_monitor_ctrl_status_q[`VLM_FLAG_BIT] <= 1'b0;
      end
    end
  end

  // read mux, registered data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd && !penable)
    begin
      case (paddr)
        `ADDR_SLEEP_CONTROL:         prdata <= {24'h0, sleep_control_q};
        `ADDR_PERIPHERAL_CLOCK_GATE: prdata <= {24'h0, peripheral_clock_gate_q};
        `ADDR_SUPPLY_MONITOR:        prdata <= {24'h0, supply_monitor_ctrl_status_q};
        `ADDR_RESET_STATUS:          prdata <= {28'h0, reset_cause_q};
        default:                     prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // peripheral gating
  // ----------------------------------------
  // gated blocks keep their state; the clock simply stops
  assign serial_clock_en      = ~peripheral_clock_gate_q[`PR_SERIAL_BIT];
  assign converter_enable     = ~peripheral_clock_gate_q[`PR_CONV_BIT];
  assign comparator_mux_allow = ~peripheral_clock_gate_q[`PR_CONV_BIT];
  assign timer_clock_en       = ~peripheral_clock_gate_q[`PR_TIMER_BIT];
  assign supply_low_irq = supply_monitor_ctrl_status_q[`VLM_FLAG_BIT] &
                          supply_monitor_ctrl_status_q[`VLM_IE_BIT] &
                          ~supply_monitor_ctrl_status_q[`VLM_RST_BIT];

  // ----------------------------------------
  // sleep controller
  // ----------------------------------------
  assign cpu_halt = (state_q != ST_RUN);
  always @(posedge pclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
    begin
      state_q           <= ST_RUN;
      halt_cnt_q        <= 32'h0;
      sleeping          <= 1'b0;
      sleep_mode_active <= `SM_IDLE;
    end
    else
    begin
      case (state_q)
        ST_RUN:
        begin
          // reserved codes are not entered
          if (sleep_instruction && sleep_control_q[`SE_BIT] &&
              (sleep_control_q[3:1] == `SM_IDLE || sleep_control_q[3:1] == `SM_NOISE_RED ||
               sleep_control_q[3:1] == `SM_POWERDOWN || sleep_control_q[3:1] == `SM_STANDBY))
          begin
            state_q           <= ST_SLEEP;
            sleeping          <= 1'b1;
            sleep_mode_active <= sleep_control_q[`SM_MSB:`SM_LSB];
          end
        end
        ST_SLEEP:
        begin
          if (wake_interrupt)
          begin
            state_q    <= ST_WAKE;
            sleeping   <= 1'b0;
            halt_cnt_q <= 32'h0;
          end
        end
        ST_WAKE:
        begin
          if (halt_cnt_q >= HALT_C - 32'h1)
            state_q <= ST_RUN;
          else
            halt_cnt_q <= halt_cnt_q + 32'h1;
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end
endmodule // sleep_power_reset_control

// ===== dv/sleep_power_reset_control_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// port checks for the reset and sleep block
// ----------------------------------------
module sleep_power_reset_control_chk
#(
  parameter TIMEOUT_CYCLES = 1310720
)
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        port_reset_n,
  input wire        core_reset_n,
  input wire        reset_vector_fetch,
  input wire        external_reset_n,
  input wire        external_reset_disable_fuse,
  input wire        watchdog_timeout,
  input wire        watchdog_reset_mode,
  input wire        sleep_instruction,
  input wire        sleeping,
  input wire [2:0]  sleep_mode_active,
  input wire        serial_clock_en,
  input wire        converter_enable,
  input wire        comparator_mux_allow,
  input wire        timer_clock_en
);
  reg  [31:0] quiet_cnt_q;
  wire        gate_wr;

  // edges seen with all sources quiet; the stretch may not end sooner
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_cnt_q <= 32'h0;
    else if (!port_reset_n)
      quiet_cnt_q <= 32'h0;
    else
      quiet_cnt_q <= quiet_cnt_q + 32'h1;
  end

  // completed gate write; writes during core reset are lost, so excluded
  assign gate_wr = psel && penable && pwrite && pready && core_reset_n && (paddr == 12'h0d4);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wdt_fire;
    core_reset_n && watchdog_timeout && watchdog_reset_mode && !$past(watchdog_timeout);
  endsequence

  a_serial_gate: assert property (gate_wr |=> serial_clock_en == !$past(pwdata[2]))
    else $error("serial clock enable wrong after gate write");
  a_conv_gate: assert property (gate_wr |=> converter_enable == !$past(pwdata[1])
    && comparator_mux_allow == !$past(pwdata[1])) else $error("converter enable wrong after gate write");
  a_timer_gate: assert property (gate_wr |=> timer_clock_en == !$past(pwdata[0]))
    else $error("timer clock enable wrong after gate write");
  a_mode_legal: assert property ($rose(sleeping) |-> sleep_mode_active inside {3'h0, 3'h1, 3'h2, 3'h4})
    else $error("sleep entered with a reserved mode");
  a_sleep_cause: assert property ($rose(sleeping) |-> $past(sleep_instruction) || $past(sleep_instruction, 2))
    else $error("sleep entered without a sleep instruction");
  a_pin_async: assert property (!external_reset_n && !external_reset_disable_fuse |-> !port_reset_n)
    else $error("reset pin low but ports not in reset");
  a_core_follow: assert property (!port_reset_n |=> !core_reset_n)
    else $error("core out of reset while a source is active");
  a_stretch_len: assert property ($rose(core_reset_n) |-> quiet_cnt_q >= TIMEOUT_CYCLES)
    else $error("internal reset released before the time-out");
  a_wdt_reset: assert property (s_wdt_fire |-> ##[1:4] !port_reset_n)
    else $error("watchdog timeout gave no reset");
  a_vector_pulse: assert property (reset_vector_fetch == $rose(core_reset_n))
    else $error("reset vector fetch not aligned with reset release");
endmodule // sleep_power_reset_control_chk

bind sleep_power_reset_control sleep_power_reset_control_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .paddr(paddr), .pwdata(pwdata), .port_reset_n(port_reset_n), .core_reset_n(core_reset_n),
  .reset_vector_fetch(reset_vector_fetch), .external_reset_n(external_reset_n),
  .external_reset_disable_fuse(external_reset_disable_fuse), .watchdog_timeout(watchdog_timeout),
  .watchdog_reset_mode(watchdog_reset_mode), .sleep_instruction(sleep_instruction), .sleeping(sleeping),
  .sleep_mode_active(sleep_mode_active), .serial_clock_en(serial_clock_en),
  .converter_enable(converter_enable), .comparator_mux_allow(comparator_mux_allow),
  .timer_clock_en(timer_clock_en)
);

// ===== dv/test_sleep_power_reset_control.sv
`timescale 1ns/1ns
`include "sleep_power_reset_defs.vh"
// ----------------------------------------
// bench: short time-out keeps the run small
// ----------------------------------------
module test_sleep_power_reset_control;
  localparam T = 20;
  reg         pclk, presetn, psel, penable, pwrite, err, lg;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg         por_active_n, supply_below_level, external_reset_n, external_reset_disable_fuse;
  reg         watchdog_timeout, watchdog_reset_mode, sleep_instruction, wake_interrupt;
  wire [31:0] prdata;
  wire        pready, pslverr, port_reset_n, core_reset_n, reset_vector_fetch, cpu_halt, sleeping;
  wire [2:0]  sleep_mode_active;
  wire        serial_clock_en, converter_enable, comparator_mux_allow, timer_clock_en, supply_low_irq;
  integer     n_fail, samples_checked, i, n;

  sleep_power_reset_control #(.TIMEOUT_CYCLES(T)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_active_n(por_active_n), .supply_below_level(supply_below_level),
    .external_reset_n(external_reset_n), .external_reset_disable_fuse(external_reset_disable_fuse),
    .watchdog_timeout(watchdog_timeout), .watchdog_reset_mode(watchdog_reset_mode),
    .sleep_instruction(sleep_instruction), .wake_interrupt(wake_interrupt),
    .port_reset_n(port_reset_n), .core_reset_n(core_reset_n), .reset_vector_fetch(reset_vector_fetch),
    .cpu_halt(cpu_halt), .sleep_mode_active(sleep_mode_active), .sleeping(sleeping),
    .serial_clock_en(serial_clock_en), .converter_enable(converter_enable),
    .comparator_mux_allow(comparator_mux_allow), .timer_clock_en(timer_clock_en),
    .supply_low_irq(supply_low_irq)
  );

  task end_of_test;
  begin
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  // one apb transfer; held until pready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    check(n < 16, 1, "pready");
    if (n == 16)
      end_of_test;
    @(posedge pclk);
  end
  endtask

  // wait for the stretched reset to end; n counts the edges
  task wait_core;
  begin
    n = 0;
    while (core_reset_n !== 1'b1 && n < 300)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    check(n < 300, 1, "core hang");
    if (n == 300)
      end_of_test;
  end
  endtask

  task t_gates;
  begin
    apb(0, `ADDR_SLEEP_CONTROL, 0);
    check(rd, 0, "sleep rst");
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1, `ADDR_PERIPHERAL_CLOCK_GATE, i);
      apb(0, `ADDR_PERIPHERAL_CLOCK_GATE, 0);
      check(rd, i, "gate rd");
      check(serial_clock_en, !i[2], "serial");
      check({converter_enable, comparator_mux_allow}, {2{!i[1]}}, "conv");
      check(timer_clock_en, !i[0], "timer");
    end
    apb(0, 12'h0fc, 0);
    check(err, 1, "unmapped");
    check(rd, 0, "unmapped");
  end
  endtask

  // every mode code, with and without the enable bit
  task t_sleep;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      lg = i[0] & (i[3:1] < 3 | i[3:1] == 4);
      apb(1, `ADDR_SLEEP_CONTROL, i);
      sleep_instruction <= 1'b1;
      @(posedge pclk);
      sleep_instruction <= 1'b0;
      repeat (3) @(posedge pclk);
      check(sleeping, lg, "sleeping");
      check(sleep_mode_active & {3{lg}}, i[3:1] & {3{lg}}, "mode");
      if (lg)
      begin
        wake_interrupt <= 1'b1;
        n = 0;
        while (cpu_halt !== 1'b0 && n < 100)
        begin
          n = n + 1;
          @(posedge pclk);
        end
        wake_interrupt <= 1'b0;
        check(n >= 16 + `WAKE_HALT_CYCLES && n < 100, 1, "wake halt");
        if (n == 100)
          end_of_test;
      end
    end
  end
  endtask

  task t_ext;
  begin
    apb(1, `ADDR_PERIPHERAL_CLOCK_GATE, 7);
    external_reset_disable_fuse <= 1'b1;
    external_reset_n <= 1'b0;
    repeat (60) @(posedge pclk);
    check(core_reset_n, 1, "fuse");
    external_reset_disable_fuse <= 1'b0;
    @(negedge pclk);
    check(port_reset_n, 0, "pin");
    repeat (60) @(posedge pclk);
    external_reset_n <= 1'b1;
    @(posedge pclk);
    wait_core;
    check(n >= T, 1, "ext delay");
    apb(0, `ADDR_PERIPHERAL_CLOCK_GATE, 0);
    check(rd, 0, "gate rst");
    apb(0, `ADDR_RESET_STATUS, 0);
    check(rd[1], 1, "ext cause");
  end
  endtask

  task t_por_wdt;
  begin
    por_active_n <= 1'b0;
    @(negedge pclk);
    check(port_reset_n, 0, "por");
    repeat (5) @(posedge pclk);
    por_active_n <= 1'b1;
    wait_core;
    apb(0, `ADDR_RESET_STATUS, 0);
    check(rd[0], 1, "por flag");
    watchdog_timeout <= 1'b1;
    repeat (5) @(posedge pclk);
    check(core_reset_n, 1, "wdt off");
    watchdog_timeout <= 1'b0;
    watchdog_reset_mode <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b1;
    @(posedge pclk);
    watchdog_timeout <= 1'b0;
    repeat (5) @(posedge pclk);
    check(core_reset_n, 0, "wdt rst");
    watchdog_reset_mode <= 1'b0;
    wait_core;
    apb(0, `ADDR_RESET_STATUS, 0);
    check(rd[2], 1, "wdt cause");
  end
  endtask

  task t_mon;
  begin
    apb(1, `ADDR_SUPPLY_MONITOR, 32'h0b);
    supply_below_level <= 1'b1;
    repeat (4) @(posedge pclk);
    check(supply_low_irq, 1, "irq");
    apb(0, `ADDR_SUPPLY_MONITOR, 0);
    check(rd[7], 1, "flag");
    supply_below_level <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(0, `ADDR_SUPPLY_MONITOR, 0);
    check({rd[7], supply_low_irq}, 0, "flag clr");
    apb(1, `ADDR_SUPPLY_MONITOR, 32'h1b);
    supply_below_level <= 1'b1;
    repeat (40) @(posedge pclk);
    check({core_reset_n, supply_low_irq}, 0, "mon rst");
    supply_below_level <= 1'b0;
    wait_core;
    apb(0, `ADDR_RESET_STATUS, 0);
    check(rd[3], 1, "mon cause");
  end
  endtask

  // free-running clock at 20 MHz
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    {n_fail, samples_checked} = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {supply_below_level, external_reset_disable_fuse, watchdog_timeout} = 0;
    {watchdog_reset_mode, sleep_instruction, wake_interrupt} = 0;
    por_active_n = 1'b1;
    external_reset_n = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_core;
    t_gates;
    t_sleep;
    t_ext;
    t_por_wdt;
    t_mon;
    end_of_test;
  end
endmodule // test_sleep_power_reset_control
